//--- design/bsq_regs.svh
// Timing, threshold and field constants for the burner safety sequencer
`ifndef BSQ_REGS_SVH
`define BSQ_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing tick
// ----------------------------------------------------------------
`define BSQ_CLK_HZ          20000000
`define BSQ_TICK_MS         100
`define BSQ_TICK_CYCLES     ((`BSQ_CLK_HZ / 1000) * `BSQ_TICK_MS)
`define BSQ_TICK_W          21

// ----------------------------------------------------------------
// Sequence intervals in milliseconds
// ----------------------------------------------------------------
`define BSQ_PREPURGE_MS     12000
`define BSQ_PREIGN_MS       12000
`define BSQ_SAFETY_MS       10000
`define BSQ_POST_ONE_MS     20000
`define BSQ_POST_TWO_MS     3000
`define BSQ_VALVE2_MS       40000
`define BSQ_RESET_MS        90000

// Interval converted to whole ticks
`define BSQ_MS2TICK(ms)     ((ms) / `BSQ_TICK_MS)
`define BSQ_TMR_W           10
`define BSQ_TMR_MAX         10'h3FF

// ----------------------------------------------------------------
// Mains voltage thresholds in volts effective
// ----------------------------------------------------------------
`define BSQ_V_W             9
`define BSQ_V_START         9'h0BB
`define BSQ_V_TRIP          9'h0A0
`define BSQ_V_NOMINAL       9'h0E6
`define BSQ_V_MARGIN_PCT    15

`endif

//--- design/bsq_pkg.sv
// Types shared by the burner safety sequencer
package bsq_pkg;

	// ----------------------------------------------------------------
	// Sequence states
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		BSQ_IDLE,
		BSQ_PREPURGE,
		BSQ_PREIGN,
		BSQ_SAFETY,
		BSQ_POSTIGN,
		BSQ_RUN,
		BSQ_LOCKOUT,
		BSQ_UV_HOLD
	} bsq_state_e;

	// ----------------------------------------------------------------
	// Field inputs and actuator outputs
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       heat_demand;
		logic       flame_seen;
		logic       reset_button;
		logic [8:0] mains_v;
	} bsq_field_s;

	typedef struct packed
	{
		logic motor;
		logic ignition;
		logic valve1;
		logic valve2;
		logic lockout_lamp;
	} bsq_act_s;

endpackage

//--- design/bsq_sequencer.sv
// Oil burner safety sequencer: start-up, supervision and lockout
//
// What this block does
// - Fixed-threshold variant starts only above 187 V
// - Below 160 V while sequencing forces undervoltage lockout
// - Undervoltage lockout restarts itself above 187 V
// - Second variant starts only above nominal minus 15%
// - Second variant: below 160 V blocks, no fuel
// - No flame by safety time end: lockout
// - Stray light in pre-purge: lockout at end
// - Flame lost while running: lockout after safety time
// - 12 s pre-purge, 12 s pre-ignition before fuel
// - Post-ignition 20 s one-stage, 3 s two-stage
// - Second valve: 40 s after release, flame present
// - Safety time 10 s; reset accepted after 90 s
// - Lockout lamp lit; reset button leaves lockout
// - Flame input low means no flame, per tick
`timescale 1ns/1ps
`include "bsq_regs.svh"

module bsq_sequencer
	import bsq_pkg::*;
#(
	parameter int         TICK_CYCLES = `BSQ_TICK_CYCLES,
	parameter bit         TWO_STAGE   = 1'b0,
	parameter bit         LV_MODE     = 1'b0,
	parameter logic [8:0] V_NOMINAL   = `BSQ_V_NOMINAL
)
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Burner field inputs
	input  wire bsq_field_s field,
	// Burner actuators and lamp
	output bsq_act_s        act,
	// Sequence state
	output bsq_state_e      state
);

	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam logic [`BSQ_TICK_W-1:0] TICK_LAST  = `BSQ_TICK_W'(TICK_CYCLES - 1);
	localparam logic [`BSQ_TMR_W-1:0]  T_PREPURGE = `BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_PREPURGE_MS));
	localparam logic [`BSQ_TMR_W-1:0]  T_PREIGN   = `BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_PREIGN_MS));
	localparam logic [`BSQ_TMR_W-1:0]  T_SAFETY   = `BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_SAFETY_MS));
	localparam logic [`BSQ_TMR_W-1:0]  T_POST     = TWO_STAGE ?
		`BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_POST_TWO_MS)) :
		`BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_POST_ONE_MS));
	localparam logic [`BSQ_TMR_W-1:0]  T_VALVE2   = `BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_VALVE2_MS));
	localparam logic [`BSQ_TMR_W-1:0]  T_RESET    = `BSQ_TMR_W'(`BSQ_MS2TICK(`BSQ_RESET_MS));

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [8:0] start_limit(input logic mode, input logic [8:0] nom);
		int scaled;
		scaled = (int'(nom) * (100 - `BSQ_V_MARGIN_PCT)) / 100;
		if (mode)
			start_limit = 9'(scaled);
		else
			start_limit = `BSQ_V_START;
	endfunction

	// Interval has run out on this tick
	function automatic logic expired(input logic tk, input logic [`BSQ_TMR_W-1:0] tm,
		input logic [`BSQ_TMR_W-1:0] lim);
		expired = tk && (tm >= lim - 10'h001);
	endfunction

	function automatic logic [`BSQ_TMR_W-1:0] tmr_step(input logic tk,
		input logic [`BSQ_TMR_W-1:0] tm);
		if (tk && (tm != `BSQ_TMR_MAX))
			tmr_step = tm + 10'h001;
		else
			tmr_step = tm;
	endfunction

	function automatic logic fuel_state(input bsq_state_e s);
		fuel_state = (s == BSQ_SAFETY) || (s == BSQ_POSTIGN) || (s == BSQ_RUN);
	endfunction

	// ----------------------------------------------------------------
	// Timing tick and flame sampling
	// ----------------------------------------------------------------
	logic [`BSQ_TICK_W-1:0] tick_cnt_r;
	logic [`BSQ_TICK_W-1:0] tick_cnt_nxt;
	logic                   tick_r;
	logic                   tick_nxt;
	logic                   flame_r;
	logic                   flame_nxt;

	always_comb
	begin
		tick_nxt     = (tick_cnt_r == TICK_LAST);
		tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 21'h000001;
		flame_nxt    = tick_r ? field.flame_seen : flame_r;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
			flame_r    <= 1'b0;
		end
		else
		begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r     <= tick_nxt;
			flame_r    <= flame_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	bsq_state_e             state_r;
	bsq_state_e             state_nxt;
	logic [`BSQ_TMR_W-1:0]  tm_r;
	logic [`BSQ_TMR_W-1:0]  tm_nxt;
	logic [`BSQ_TMR_W-1:0]  v2_r;
	logic [`BSQ_TMR_W-1:0]  v2_nxt;
	logic [`BSQ_TMR_W-1:0]  loss_r;
	logic [`BSQ_TMR_W-1:0]  loss_nxt;
	logic                   stray_r;
	logic                   stray_nxt;
	bsq_act_s               act_r;
	bsq_act_s               act_nxt;
	logic                   volt_ok;
	logic                   volt_trip;
	logic                   active;

	always_comb
	begin
		volt_ok   = (field.mains_v > start_limit(LV_MODE, V_NOMINAL));
		volt_trip = (field.mains_v < `BSQ_V_TRIP);
		active    = (state_r != BSQ_IDLE) && (state_r != BSQ_LOCKOUT) &&
			(state_r != BSQ_UV_HOLD);
		state_nxt = state_r;
		stray_nxt = stray_r;

		unique case (state_r)
			BSQ_IDLE:
				if (field.heat_demand && volt_ok && !volt_trip)
					state_nxt = BSQ_PREPURGE;
			BSQ_PREPURGE:
			begin
				if (tick_r && flame_r)
					stray_nxt = 1'b1;
				if (expired(tick_r, tm_r, T_PREPURGE))
					state_nxt = (stray_r || (tick_r && flame_r)) ? BSQ_LOCKOUT : BSQ_PREIGN;
			end
			BSQ_PREIGN:
				if (expired(tick_r, tm_r, T_PREIGN))
					state_nxt = BSQ_SAFETY;
			BSQ_SAFETY:
				if (flame_r)
					state_nxt = BSQ_POSTIGN;
				else if (expired(tick_r, tm_r, T_SAFETY))
					state_nxt = BSQ_LOCKOUT;
			BSQ_POSTIGN:
				if (expired(tick_r, tm_r, T_POST))
					state_nxt = BSQ_RUN;
			BSQ_RUN:
				state_nxt = BSQ_RUN;
			BSQ_LOCKOUT:
				if (field.reset_button && (tm_r >= T_RESET))
					state_nxt = BSQ_IDLE;
			BSQ_UV_HOLD:
				if (volt_ok)
					state_nxt = BSQ_IDLE;
		endcase

		// Flame lost after establishment
		if ((state_r == BSQ_POSTIGN || state_r == BSQ_RUN) && !flame_r &&
			expired(tick_r, loss_r, T_SAFETY))
			state_nxt = BSQ_LOCKOUT;

		// Thermostat chain opened: orderly shutdown
		if (active && !field.heat_demand)
			state_nxt = BSQ_IDLE;

		// Undervoltage overrides everything while sequencing
		if (active && volt_trip)
			state_nxt = LV_MODE ? BSQ_LOCKOUT : BSQ_UV_HOLD;

		if (state_nxt != BSQ_PREPURGE)
			stray_nxt = 1'b0;

		// Interval timers
		tm_nxt   = (state_nxt != state_r) ? '0 : tmr_step(tick_r, tm_r);
		v2_nxt   = fuel_state(state_nxt) ? tmr_step(tick_r, v2_r) : '0;
		loss_nxt = (fuel_state(state_nxt) && !flame_r) ? tmr_step(tick_r, loss_r) : '0;

		// Actuators follow the next state; lockout leaves only the lamp
		act_nxt.motor        = (state_nxt == BSQ_PREPURGE) || (state_nxt == BSQ_PREIGN) ||
			fuel_state(state_nxt);
		act_nxt.ignition     = (state_nxt == BSQ_PREIGN) || (state_nxt == BSQ_SAFETY) ||
			(state_nxt == BSQ_POSTIGN);
		act_nxt.valve1       = fuel_state(state_nxt);
		act_nxt.valve2       = TWO_STAGE && fuel_state(state_nxt) &&
			(act_r.valve2 || ((v2_r >= T_VALVE2) && flame_r));
		act_nxt.lockout_lamp = (state_nxt == BSQ_LOCKOUT) || (state_nxt == BSQ_UV_HOLD);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= BSQ_IDLE;
			tm_r    <= '0;
			v2_r    <= '0;
			loss_r  <= '0;
			stray_r <= 1'b0;
			act_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			tm_r    <= tm_nxt;
			v2_r    <= v2_nxt;
			loss_r  <= loss_nxt;
			stray_r <= stray_nxt;
			act_r   <= act_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign act   = act_r;
	assign state = state_r;

endmodule

//--- tb/bsq_seq_props.sv
// Port checks for the burner safety sequencer
`timescale 1ns/1ps
module bsq_seq_props
	import bsq_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// Field inputs and outputs
	input wire bsq_field_s field,
	input wire bsq_act_s   act,
	input wire bsq_state_e state
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_lockout_all_off: assert property (state == BSQ_LOCKOUT |-> act == 5'h01)
		else $error("lockout outputs wrong");
	a_purge_motor_only: assert property (state == BSQ_PREPURGE |-> act == 5'h10)
		else $error("pre-purge outputs wrong");
	a_uv_hold_dark: assert property (state == BSQ_UV_HOLD |-> act == 5'h01)
		else $error("fuel during undervoltage");
	a_low_v_idle: assert property (state == BSQ_IDLE && field.mains_v <= 9'h0BB
		|=> state == BSQ_IDLE)
		else $error("start at low voltage");
	a_uv_trip_fast: assert property (state inside {[BSQ_PREPURGE:BSQ_RUN]}
		&& field.mains_v < 9'h0A0 |=> state inside {BSQ_UV_HOLD, BSQ_LOCKOUT})
		else $error("undervoltage missed");
	a_uv_auto_restart: assert property (state == BSQ_UV_HOLD && field.mains_v > 9'h0BB
		|=> state == BSQ_IDLE)
		else $error("no restart after undervoltage");
	a_lock_holds: assert property (state == BSQ_LOCKOUT && !field.reset_button
		|=> state == BSQ_LOCKOUT)
		else $error("lockout left without button");
	a_ignite_outputs: assert property (state == BSQ_PREIGN |-> act == 5'h18)
		else $error("pre-ignition outputs wrong");
	a_flame_wait_outputs: assert property (state inside {BSQ_SAFETY, BSQ_POSTIGN}
		|-> act == 5'h1C)
		else $error("ignition phase outputs wrong");
	a_fuel_order: assert property ($rose(act.valve1) |-> $past(state) == BSQ_PREIGN)
		else $error("fuel released out of order");
endmodule

bind bsq_sequencer bsq_seq_props u_props (.clk_sys(clk_sys), .resetn(resetn),
	.field(field), .act(act), .state(state));

//--- tb/bsq_burner_model.sv
// Behavioural burner: flame from fuel and ignition, plus stray light
`timescale 1ns/1ps
module bsq_burner_model
	import bsq_pkg::*;
(
	// Clock
	input  wire logic     clk_sys,
	// Actuators and test controls
	input  wire bsq_act_s act,
	input  wire logic     lit_ok,
	input  wire logic     stray,
	// Flame sensor
	output logic          flame
);
	initial flame = 1'b0;
	// Flame needs fuel and either ignition or a burning flame
	always @(negedge clk_sys)
		flame <= stray | (lit_ok & act.valve1 & (flame | act.ignition));
endmodule

//--- tb/tb.sv
// Self-checking bench for the burner safety sequencer
`timescale 1ns/1ps
module tb;
	import bsq_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        demand = 1'b0;
	logic        rst_btn = 1'b0;
	logic        lit_ok = 1'b1;
	logic        stray = 1'b0;
	logic        flame;
	logic [8:0]  volts = 9'h0E6;
	logic [31:0] lfsr_r = 32'h0E4CBD4C;
	bsq_field_s  field;
	bsq_act_s    act;
	bsq_state_e  state;
	bsq_act_s    act_lv;
	bsq_state_e  state_lv;
	bsq_state_e  last_st = BSQ_IDLE;
	bsq_state_e  exp_st[$];
	int          exp_lo[$];
	int          dwell = 0;
	int          i;
	int          miscompares = 0;
	int          n_checks = 0;
	assign field = {demand, flame, rst_btn, volts};
	bsq_sequencer #(.TICK_CYCLES(4), .TWO_STAGE(1'b1)) uut (.clk_sys(clk_sys),
		.resetn(resetn), .field(field), .act(act), .state(state));
	bsq_sequencer #(.TICK_CYCLES(4), .TWO_STAGE(1'b0), .LV_MODE(1'b1)) uut_lv (
		.clk_sys(clk_sys), .resetn(resetn), .field(field), .act(act_lv), .state(state_lv));
	bsq_burner_model u_burner (.clk_sys(clk_sys), .act(act), .lit_ok(lit_ok),
		.stray(stray), .flame(flame));
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic ex(input bsq_state_e s, input int lo);
		exp_st.push_back(s);
		exp_lo.push_back(lo);
	endtask
	task automatic drain();
		for (int k = 0; k < 20000 && exp_st.size() > 0; k++)
			@(negedge clk_sys);
		if (exp_st.size() > 0)
		begin
			miscompares++;
			conclude();
		end
	endtask
	task automatic release_lock();
		repeat (3700) @(negedge clk_sys);
		rst_btn = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst_btn = 1'b0;
	endtask
	// ----------------------------------------------------------------
	// State watcher: each change must match the oldest note
	// ----------------------------------------------------------------
	always @(negedge clk_sys)
	begin
		dwell++;
		if (state !== last_st)
		begin
			if (exp_st.size() == 0)
				chk(32'(state), 32'(last_st));
			else
			begin
				chk(32'(state), 32'(exp_st[0]));
				if (exp_lo[0] > 0)
					chk(32'(dwell >= exp_lo[0] && dwell <= exp_lo[0] + 8), 32'h1);
				void'(exp_st.pop_front());
				void'(exp_lo.pop_front());
			end
			dwell = 0;
		end
		last_st = state;
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(negedge clk_sys);
		resetn = 1'b1;
		ex(BSQ_PREPURGE, 0);
		ex(BSQ_PREIGN, 476);
		ex(BSQ_SAFETY, 476);
		ex(BSQ_POSTIGN, 0);
		ex(BSQ_RUN, 116);
		demand = 1'b1;
		drain();
		chk(32'(act), 32'h14);
		chk(32'(act_lv), 32'h1C);
		for (i = 0; i < 2000 && act.valve2 !== 1'b1; i++)
			@(negedge clk_sys);
		chk(32'(act), 32'h16);
		chk(32'(act_lv), 32'h14);
		chk(32'(i > 1400), 32'h1);
		lit_ok = 1'b0;
		ex(BSQ_LOCKOUT, 0);
		drain();
		chk(32'(act), 32'h01);
		lfsr_r = lfsr(lfsr_r);
		repeat (10 + lfsr_r[9:0]) @(negedge clk_sys);
		rst_btn = 1'b1;
		repeat (20) @(negedge clk_sys);
		rst_btn = 1'b0;
		chk(32'(state), 32'(BSQ_LOCKOUT));
		stray = 1'b1;
		ex(BSQ_IDLE, 0);
		ex(BSQ_PREPURGE, 0);
		ex(BSQ_LOCKOUT, 476);
		release_lock();
		drain();
		stray = 1'b0;
		ex(BSQ_IDLE, 0);
		ex(BSQ_PREPURGE, 0);
		ex(BSQ_PREIGN, 476);
		ex(BSQ_SAFETY, 476);
		ex(BSQ_LOCKOUT, 396);
		release_lock();
		drain();
		ex(BSQ_IDLE, 0);
		ex(BSQ_PREPURGE, 0);
		release_lock();
		drain();
		ex(BSQ_UV_HOLD, 0);
		lfsr_r = lfsr(lfsr_r);
		volts = 9'(lfsr_r % 160);
		drain();
		chk(32'(act), 32'h01);
		chk(32'(state_lv), 32'(BSQ_LOCKOUT));
		chk(32'(act_lv), 32'h01);
		volts = 9'h0AA;
		repeat (50) @(negedge clk_sys);
		ex(BSQ_IDLE, 0);
		ex(BSQ_PREPURGE, 0);
		lfsr_r = lfsr(lfsr_r);
		volts = 9'(188 + lfsr_r % 300);
		drain();
		ex(BSQ_IDLE, 0);
		demand = 1'b0;
		drain();
		release_lock();
		volts = 9'h0BB;
		demand = 1'b1;
		repeat (50) @(negedge clk_sys);
		ex(BSQ_PREPURGE, 0);
		volts = 9'h0BC;
		drain();
		chk(32'(state_lv), 32'(BSQ_IDLE));
		volts = 9'h0C4;
		repeat (2) @(negedge clk_sys);
		chk(32'(state_lv), 32'(BSQ_PREPURGE));
		conclude();
	end
endmodule
